// ===== common/idle_domain_control_defines.svh
/*
 * Offsets, field positions, reset values and widths of the idle domain
 * control block. Assumes inclusion by bare name from the package and
 * the design files.
 */
`ifndef IDLE_DOMAIN_CONTROL_DEFINES_SVH
`define IDLE_DOMAIN_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define IDLE_STATE_REG_IDX 20'h00002
`define IDLE_SETUP_REG_IDX 20'h00001
`define SLEEP_SELECT_IDX 20'h09400

// ----------------------------------------------------------------------
// Idle setup and idle state bit positions.
// ----------------------------------------------------------------------
`define CORE_BIT 0
`define MASTER_GROUP_BIT 1
`define INSTR_CACHE_BIT 2
`define SLAVE_GROUP_BIT 3
`define CLOCK_GEN_BIT 4
`define EXT_MEMORY_BIT 5
`define IO_SPACE_PORT_BIT 6
`define DMA_PORT_BIT 7
`define FETCH_PORT_BIT 8

// ----------------------------------------------------------------------
// Widths and reset values.
// ----------------------------------------------------------------------
`define DOMAIN_COUNT 9
`define SLEEP_SEL_WIDTH 14
`define IDLE_SETUP_RESET 9'h000
`define SLEEP_SELECT_RESET 14'h0000
`define GATE_RESET 9'h000

// ----------------------------------------------------------------------
// AXI4-Lite responses.
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// ===== common/idle_domain_control_pkg.sv
/*
 * Types shared by the idle domain control design files.
 * Assumes the defines header is on the include path.
 */
`include "idle_domain_control_defines.svh"

package idle_domain_control_pkg;

	// Which register an address selects.
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_SETUP,
		SEL_STATE,
		SEL_SLEEP
	} reg_sel_t;

endpackage

// ===== design/stop_ack_sync.sv
/*
 * Two-flop synchroniser for a vector of level signals.
 * Assumes each bit is a slow level from another clock domain.
 */
`timescale 1ns/1ps

module stop_ack_sync #(
	parameter int WIDTH = 9
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// The first stage is read only by the second stage.
	always_comb begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;

endmodule

// ===== design/idle_domain_control.sv
/*
 * Idle domain control: holds the idle setup, module sleep select and
 * idle state registers behind an AXI4-Lite slave, and on each executed
 * IDLE instruction drives the gate requests of the clock domains.
 * Assumes idle_exec and wake come from logic on clk; the stopped
 * acknowledges come from the gated domains and are synchronised here.
 */
// Decided for this implementation: register access over AXI4-Lite.

`timescale 1ns/1ps

`include "idle_domain_control_defines.svh"

module idle_domain_control
	import idle_domain_control_pkg::*;
#(
	parameter int ADDR_WIDTH = 20
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic idle_exec,
	input wire logic wake,
	input wire logic [`DOMAIN_COUNT-1:0] domain_stopped,
	output logic [`DOMAIN_COUNT-1:0] domain_gate,
	output logic [`SLEEP_SEL_WIDTH-1:0] periph_gate,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`DOMAIN_COUNT-1:0] setup;
		logic [`SLEEP_SEL_WIDTH-1:0] sleep_sel;
		logic [`DOMAIN_COUNT-1:0] gate;
		logic [`SLEEP_SEL_WIDTH-1:0] pgate;
		logic [`DOMAIN_COUNT-1:0] state;
		logic aw_have;
		reg_sel_t aw_sel;
		logic w_have;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
	} ctrl_state_t;

	ctrl_state_t st_q;
	ctrl_state_t st_d;
	logic [`DOMAIN_COUNT-1:0] stopped_sync;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Byte address bits 1:0 are ignored; each register is one word.
	function automatic reg_sel_t decode(input logic [ADDR_WIDTH-1:0] a);
		logic [ADDR_WIDTH-1:0] idx;
		idx = a >> 2;
		if (idx == `IDLE_SETUP_REG_IDX) begin
			decode = SEL_SETUP;
		end else if (idx == `IDLE_STATE_REG_IDX) begin
			decode = SEL_STATE;
		end else if (idx == `SLEEP_SELECT_IDX) begin
			decode = SEL_SLEEP;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	// Merges a 16-bit word under the two low byte strobes.
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] be);
		merge = old;
		if (be[0]) begin
			merge[7:0] = nw[7:0];
		end
		if (be[1]) begin
			merge[15:8] = nw[15:8];
		end
	endfunction

	// ------------------------------------------------------------------
	// Stopped acknowledge synchroniser
	// ------------------------------------------------------------------
	// The acknowledges come from domains whose clocks may be stopped,
	// so they are resampled twice before the state register sees them.
	stop_ack_sync #(
		.WIDTH(`DOMAIN_COUNT)
	) u_ack_sync (
		.clk(clk),
		.srst(srst),
		.async_in(domain_stopped),
		.sync_out(stopped_sync)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [15:0] merged;
		logic [15:0] state_word;
		reg_sel_t rsel;
		merged = '0;
		state_word = '0;
		rsel = SEL_NONE;
		st_d = st_q;

		// Status follows what the domains report, not what was asked.
		st_d.state = stopped_sync;

		// Wake releases the non-peripheral domains; peripherals keep
		// their gating until the next IDLE decides for them.
		if (wake) begin
			st_d.gate = `GATE_RESET;
		end

		// An IDLE in the same cycle as a wake wins, since the core has
		// just asked to sleep again and must not be left running.
		if (idle_exec) begin
			st_d.gate[`CORE_BIT] = st_q.setup[`CORE_BIT];
			st_d.gate[`MASTER_GROUP_BIT] =
				st_q.setup[`MASTER_GROUP_BIT];
			st_d.gate[`INSTR_CACHE_BIT] =
				st_q.setup[`INSTR_CACHE_BIT];
			st_d.gate[`SLAVE_GROUP_BIT] = st_q.setup[`SLAVE_GROUP_BIT];
			st_d.gate[8:4] = st_q.setup[8:4];
			if (st_q.setup[`SLAVE_GROUP_BIT]) begin
				st_d.pgate = st_q.sleep_sel;
			end else begin
				st_d.pgate = '0;
			end
		end

		// Write address and data may come in either order.
		st_d.awready = 1'b0;
		st_d.wready = 1'b0;
		if (s_axi_awvalid && st_q.awready) begin
			st_d.aw_have = 1'b1;
			st_d.aw_sel = decode(s_axi_awaddr);
		end
		if (s_axi_wvalid && st_q.wready) begin
			st_d.w_have = 1'b1;
			st_d.wdata = s_axi_wdata[15:0];
			st_d.wstrb = s_axi_wstrb[1:0];
		end

		// Configuration writes only store; gating waits for IDLE.
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `RESP_OKAY;
			case (st_q.aw_sel)
				SEL_SETUP: begin
					merged = merge({7'h00, st_q.setup},
						st_q.wdata, st_q.wstrb);
					st_d.setup = merged[8:0];
				end
				SEL_SLEEP: begin
					merged = merge({2'h0, st_q.sleep_sel},
						st_q.wdata, st_q.wstrb);
					st_d.sleep_sel = merged[13:0];
				end
				SEL_STATE: begin
					st_d.bresp = `RESP_SLVERR;
				end
				default: begin
					st_d.bresp = `RESP_DECERR;
				end
			endcase
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (!st_d.aw_have && !st_d.bvalid && !st_q.awready) begin
			st_d.awready = 1'b1;
		end
		if (!st_d.w_have && !st_d.bvalid && !st_q.wready) begin
			st_d.wready = 1'b1;
		end

		// Read path: one read at a time, answered a cycle after taken.
		// Data is captured when the address is taken, so it cannot move
		// while rvalid waits for a slow rready.
		state_word = {7'h00, st_q.state};
		state_word[`FETCH_PORT_BIT] =
			st_q.state[`FETCH_PORT_BIT];
		state_word[`DMA_PORT_BIT] = st_q.state[`DMA_PORT_BIT];
		state_word[`IO_SPACE_PORT_BIT] =
			st_q.state[`IO_SPACE_PORT_BIT];
		state_word[`EXT_MEMORY_BIT] =
			st_q.state[`EXT_MEMORY_BIT];
		state_word[`CLOCK_GEN_BIT] =
			st_q.state[`CLOCK_GEN_BIT];
		state_word[`SLAVE_GROUP_BIT] =
			st_q.state[`SLAVE_GROUP_BIT];
		state_word[`INSTR_CACHE_BIT] =
			st_q.state[`INSTR_CACHE_BIT];
		state_word[`MASTER_GROUP_BIT] =
			st_q.state[`MASTER_GROUP_BIT];
		state_word[`CORE_BIT] = st_q.state[`CORE_BIT];

		st_d.arready = 1'b0;
		if (s_axi_arvalid && st_q.arready) begin
			rsel = decode(s_axi_araddr);
			st_d.rvalid = 1'b1;
			st_d.rresp = `RESP_OKAY;
			case (rsel)
				SEL_SETUP: begin
					st_d.rdata = {7'h00, st_q.setup};
				end
				SEL_STATE: begin
					st_d.rdata = state_word;
				end
				SEL_SLEEP: begin
					st_d.rdata = {2'h0, st_q.sleep_sel};
				end
				default: begin
					st_d.rdata = 16'h0000;
					st_d.rresp = `RESP_DECERR;
				end
			endcase
		end
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (!st_d.rvalid && !st_q.arready) begin
			st_d.arready = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Reset drops every gate request; setup and select take their reset
	// values by name so that a change of reset value lands only here.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= '0;
			st_q.setup <= `IDLE_SETUP_RESET;
			st_q.sleep_sel <= `SLEEP_SELECT_RESET;
			st_q.gate <= `GATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign domain_gate = st_q.gate;
	assign periph_gate = st_q.pgate;
	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = {16'h0000, st_q.rdata};
	assign s_axi_rresp = st_q.rresp;

endmodule

// ===== verif/idle_domain_control_sva.sv
/*
 * Port checker for the idle domain control block.
 * Assumes one clock, clk, with srst as its synchronous reset.
 */
`timescale 1ns/1ps

module idle_domain_control_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic idle_exec,
	input wire logic wake,
	input wire logic [8:0] domain_gate,
	input wire logic [13:0] periph_gate,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	gate_hold_a: assert property (
		!idle_exec && !wake |=> $stable(domain_gate))
		else $error("domain gate moved without idle or wake");
	wake_clear_a: assert property (
		wake && !idle_exec |=> domain_gate == 9'h000)
		else $error("wake left a domain gated");
	periph_hold_a: assert property (
		!idle_exec |=> $stable(periph_gate))
		else $error("peripheral gate moved without idle");
	slave_off_a: assert property (
		idle_exec && !wake |=> domain_gate[3] || periph_gate == 14'h0000)
		else $error("peripherals gated with group bit clear");
	aw_busy_a: assert property (
		s_axi_bvalid |-> !s_axi_awready)
		else $error("write address ready during response");
	ar_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	rd_upper_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	rd_decerr_a: assert property (
		s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
		else $error("decode error with nonzero data");
endmodule

bind idle_domain_control idle_domain_control_sva idle_domain_control_sva_i (
	.clk(clk), .srst(srst), .idle_exec(idle_exec), .wake(wake),
	.domain_gate(domain_gate), .periph_gate(periph_gate),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_awready(s_axi_awready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== verif/idle_domain_control_tb.sv
/*
 * Self-checking bench for the idle domain control block.
 * Assumes the bound checker; the bench stands in for the core and bus.
 */
`timescale 1ns/1ps

module idle_domain_control_tb
	import idle_domain_control_pkg::*;
;
	localparam logic [19:0] A_SET = 20'h00004;
	localparam logic [19:0] A_ST = 20'h00008;
	localparam logic [19:0] A_SEL = 20'h25000;
	localparam logic [19:0] A_BAD = 20'h00010;
	logic clk, srst, idle_exec, wake, awv, awr, wv, wr_q, bv, br;
	logic arv, arr, rv, rr;
	logic [8:0] stopped, dg;
	logic [13:0] pg;
	logic [19:0] awa, ara;
	logic [31:0] wd, rd_q;
	logic [3:0] ws;
	logic [1:0] bresp, rresp;
	int n_mismatch, compares;

	idle_domain_control idle_domain_control_i (
		.clk(clk), .srst(srst), .idle_exec(idle_exec), .wake(wake),
		.domain_stopped(stopped), .domain_gate(dg), .periph_gate(pg),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_q), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd_q), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic report_and_stop();
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bound(input int n);
		if (n > 50) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask

	// ----------------------------------------------------------------
	// Bus cycles.
	// ----------------------------------------------------------------
	// Address and data are offered together and dropped once taken.
	task automatic wr(input logic [19:0] a, input logic [15:0] d,
		input logic [3:0] s, input logic [1:0] r);
		int n;
		bit dn;
		n = 0;
		dn = 0;
		@(posedge clk);
		awa <= a;
		wd <= {16'h0000, d};
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!dn) begin
			@(posedge clk);
			n++;
			if (awr) awv <= 1'b0;
			if (wr_q) wv <= 1'b0;
			if (bv) begin
				dn = 1;
				br <= 1'b0;
				chk(32'(bresp), 32'(r));
			end
			bound(n);
		end
	endtask

	task automatic rc(input logic [19:0] a, input logic [31:0] e,
		input logic [1:0] r);
		int n;
		bit dn;
		n = 0;
		dn = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!dn) begin
			@(posedge clk);
			n++;
			if (arr) arv <= 1'b0;
			if (rv) begin
				dn = 1;
				rr <= 1'b0;
				chk(rd_q, e);
				chk(32'(rresp), 32'(r));
			end
			bound(n);
		end
	endtask

	// Gate outputs land on the same edge that samples the pulse.
	task automatic pulse(input bit w);
		@(posedge clk);
		if (w) wake <= 1'b1;
		else idle_exec <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		idle_exec <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// The acknowledge crosses two flops and a register before a read.
	task automatic st(input int i);
		@(posedge clk);
		stopped <= 9'(1 << i);
		repeat (5) @(posedge clk);
		rc(A_ST, 32'h1 << i, 2'h0);
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_reset();
		rc(A_SET, 32'h0, 2'h0);
		rc(A_SEL, 32'h0, 2'h0);
		rc(A_ST, 32'h0, 2'h0);
	endtask

	task automatic t_regs();
		wr(A_SET, 16'hffff, 4'hf, 2'h0);
		rc(A_SET, 32'h1ff, 2'h0);
		wr(A_SEL, 16'hffff, 4'h1, 2'h0);
		rc(A_SEL, 32'h0ff, 2'h0);
		wr(A_SEL, 16'hffff, 4'h3, 2'h0);
		rc(A_SEL, 32'h3fff, 2'h0);
		wr(A_ST, 16'hffff, 4'hf, 2'h2);
		rc(A_ST, 32'h0, 2'h0);
		wr(A_BAD, 16'h1234, 4'hf, 2'h3);
		rc(A_BAD, 32'h0, 2'h3);
		chk(32'({dg, pg}), 32'h0);
	endtask

	task automatic t_gate();
		pulse(0);
		chk(32'(dg), 32'h1ff);
		chk(32'(pg), 32'h3fff);
		wr(A_SEL, 16'h2a55, 4'h3, 2'h0);
		pulse(0);
		chk(32'(pg), 32'h2a55);
		wr(A_SET, 16'h0005, 4'h3, 2'h0);
		pulse(0);
		chk(32'(dg), 32'h005);
		chk(32'(pg), 32'h0);
		pulse(1);
		chk(32'(dg), 32'h0);
	endtask

	// A late rready: the read answer must stand unchanged until taken.
	task automatic t_stall();
		int n;
		n = 0;
		@(posedge clk);
		ara <= A_SET;
		arv <= 1'b1;
		while (!rv) begin
			@(posedge clk);
			n++;
			if (arr) arv <= 1'b0;
			bound(n);
		end
		repeat (2) @(posedge clk);
		rr <= 1'b1;
		@(posedge clk);
		rr <= 1'b0;
		chk(32'(rv), 32'h1);
		chk(rd_q, 32'h005);
		chk(32'(rresp), 32'h0);
	endtask

	initial begin
		n_mismatch = 0;
		compares = 0;
		srst = 1'b1;
		{idle_exec, wake, awv, wv, br, arv, rr} = 7'h00;
		stopped = 9'h000;
		awa = 20'h0;
		ara = 20'h0;
		wd = 32'h0;
		ws = 4'h0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_regs();
		t_gate();
		t_stall();
		for (int i = 0; i < 5; i++) st(i);
		for (int i = 5; i < 9; i++) st(i);
		report_and_stop();
	end
endmodule
